// [bench/fwsc_top_sva.sv]
// Purpose: port checks for the step controller
// Assumes: clk_en_i held high
// Notes: gap counts cycles since the last step
module fwsc_top_chk
(
  input wire logic                        ref_clk_i,     // system clock
  input wire logic                        reset_n_i,     // async reset
  input wire logic                        cmd_valid_i,   // byte strobe
  input wire logic [7:0]                  cmd_byte_i,    // command byte
  input wire logic [fwsc_pkg::IVL_W-1:0]  slow_ivl_i,    // slow interval
  input wire logic [fwsc_pkg::IVL_W-1:0]  fast_ivl_i,    // fast interval
  input wire fwsc_pkg::fwsc_drive_t       drive_o,       // step, dir
  input wire logic                        busy_o,        // active
  input wire logic                        hold_xfer_o,   // transfer hold
  input wire logic                        thr_inhibit_o  // inhibit
);
  import fwsc_pkg::*;
  logic [IVL_W-1:0] gap, next_gap;             // cycles since step
  logic             fseen, next_fseen;         // last step fast
  logic             sseen, next_sseen;         // last step slow
  logic             wcmd;                      // wheel byte taken
  assign wcmd = cmd_valid_i && cmd_byte_i >= CMD_WHEEL_LO && cmd_byte_i <= CMD_WHEEL_HI;
  // spacing trackers
  always_comb
  begin
    next_gap = drive_o.step ? IVL_W'(1) : gap + IVL_W'(1);
    next_fseen = hold_xfer_o & (drive_o.step | fseen);
    next_sseen = busy_o & ~hold_xfer_o & (drive_o.step | sseen);
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      gap <= '0;
      fseen <= 1'h0;
      sseen <= 1'h0;
    end
    else
    begin
      gap <= next_gap;
      fseen <= next_fseen;
      sseen <= next_sseen;
    end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_inhibit_busy: assert property (busy_o |-> thr_inhibit_o)
    else $error("inhibit low while busy");
  a_step_inhibit: assert property (drive_o.step |-> thr_inhibit_o)
    else $error("step without inhibit");
  a_hold_busy: assert property (hold_xfer_o |-> busy_o)
    else $error("transfer hold while idle");
  a_fast_gap: assert property (drive_o.step && hold_xfer_o && fseen |-> gap == fast_ivl_i)
    else $error("fast spacing off");
  a_slow_gap: assert property (drive_o.step && !hold_xfer_o && sseen |-> gap >= slow_ivl_i)
    else $error("slow spacing short");
  a_step_single: assert property (drive_o.step |=> !drive_o.step)
    else $error("step wider than a cycle");
  a_idle_start: assert property (wcmd && !busy_o |-> ##[1:3] busy_o)
    else $error("request not started");
  a_count_idle: assert property (!wcmd [*4] ##0 (cmd_valid_i && cmd_byte_i[7] && !busy_o) |=> !busy_o [*3])
    else $error("count byte started a move");
  c_fast: cover property (drive_o.step && hold_xfer_o);
  c_slow: cover property (drive_o.step && !hold_xfer_o);
  c_done: cover property ($fell(busy_o));
endmodule

bind fwsc_top fwsc_top_chk u_fwsc_top_chk
(
  .ref_clk_i, .reset_n_i, .cmd_valid_i, .cmd_byte_i, .slow_ivl_i, .fast_ivl_i,
  .drive_o, .busy_o, .hold_xfer_o, .thr_inhibit_o
);

// [bench/fwsc_wheel_model.sv]
// Purpose: wheel with encoder slots every six steps
// Assumes: 96 steps a turn, 16 slots
// Notes: broken_i blanks the encoder
module fwsc_wheel_model
(
  input  wire logic                    ref_clk_i,  // system clock
  input  wire fwsc_pkg::fwsc_drive_t   drive_i,    // step and direction
  input  wire logic                    broken_i,   // encoder failure
  output logic [fwsc_pkg::POS_W-1:0]   encoder_o   // slot code
);
  timeunit 1ns;
  timeprecision 1ps;
  import fwsc_pkg::*;
  int angle = 0;  // steps from slot zero
  // one step a pulse, dir high counts up
  always @(posedge ref_clk_i)
    if (drive_i.step)
      angle <= (angle + (drive_i.dir ? 1 : 95)) % 96;
  // code only on a slot, else no position
  always_comb
    encoder_o = (broken_i || angle % 6 != 0) ? POS_INVALID : POS_W'(angle / 6);
endmodule

// [bench/test_fwsc_top.sv]
// Purpose: self-checking bench for the step controller
// Assumes: short step intervals stand in for real ones
// Notes: a result is a quiet spell after wheel activity
module test_fwsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fwsc_pkg::*;
  // expected outcome of one operation
  typedef struct {
    int               n1;    // pulses, dir high
    int               n0;    // pulses, dir low
    logic             fast;  // fast run seen
    logic             fail;  // search gave up
    logic             pchk;  // position checked
    logic [POS_W-1:0] pos;   // expected position
  } fwsc_exp_t;
  logic             ref_clk_i = 0, reset_n_i = 0, cmd_valid_i = 0, yield_i = 1, broken = 0;
  logic [7:0]       cmd_byte_i = '0;
  logic [IVL_W-1:0] slow_ivl_i = 28'h14, fast_ivl_i = 28'h8;
  logic [POS_W-1:0] encoder_i, position_o;
  fwsc_drive_t      drive_o;
  logic             queue_full_o, busy_o, hold_xfer_o, thr_inhibit_o, seek_fail_o;
  logic [31:0]      yield_pat = 32'hFFFF_FFFF;  // scheduler load pattern
  fwsc_exp_t        exp_q[$], e;                // notes and current note
  int               err_count = 0, cmp_count = 0, n1 = 0, n0 = 0, quiet = 0, cyc = 0;
  logic             act = 0, fseen = 0;         // activity, fast seen

  always #5 ref_clk_i = ~ref_clk_i;

  fwsc_top u_fwsc_top (.ref_clk_i, .reset_n_i, .clk_en_i(1'h1), .cmd_valid_i, .cmd_byte_i,
    .slow_ivl_i, .fast_ivl_i, .yield_i, .encoder_i, .drive_o, .queue_full_o, .busy_o,
    .hold_xfer_o, .thr_inhibit_o, .seek_fail_o, .position_o);
  fwsc_wheel_model u_fwsc_wheel_model (.ref_clk_i, .drive_i(drive_o), .broken_i(broken),
    .encoder_o(encoder_i));

  // slow slot grants follow the load pattern
  always @(negedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    yield_i <= yield_pat[cyc % 32];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t: %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask

  // count pulses, close a result after quiet
  always @(posedge ref_clk_i)
  begin
    if (drive_o.step === 1'h1)
      if (drive_o.dir)
        n1++;
      else
        n0++;
    if (hold_xfer_o === 1'h1)
      fseen = 1;
    if (busy_o !== 1'h0 || (cmd_valid_i && cmd_byte_i inside {[CMD_WHEEL_LO:CMD_WHEEL_HI]}))
    begin
      act = 1;
      quiet = 0;
    end
    else if (act && ++quiet == 12)
    begin
      act = 0;
      if (exp_q.size() == 0)
        check(0, 1, "unnoted result");
      else
      begin
        e = exp_q.pop_front();
        check(n1, e.n1, "dir high pulses");
        check(n0, e.n0, "dir low pulses");
        check(fseen, e.fast, "fast rate");
        check(seek_fail_o, e.fail, "search fail");
        if (e.pchk)
          check(position_o, e.pos, "position");
      end
      n1 = 0;
      n0 = 0;
      fseen = 0;
    end
  end

  // strobe one byte at the falling edge
  task automatic send(input logic [7:0] b);
    @(negedge ref_clk_i);
    cmd_valid_i = 1'h1;
    cmd_byte_i = b;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'h0;
  endtask

  // note the outcome, then send
  task automatic op(input logic [7:0] b, input fwsc_exp_t x);
    exp_q.push_back(x);
    send(b);
  endtask

  // wait, bounded, until all notes are taken
  task automatic settle();
    for (int i = 0; i < 30000 && exp_q.size() != 0; i++)
      @(posedge ref_clk_i);
    if (exp_q.size() != 0)
      check(0, 1, "no result");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int n;
    void'($urandom(12));
    yield_pat = $urandom() | 32'h1111_1111;
    repeat (16) @(negedge ref_clk_i);
    reset_n_i = 1'h1;
    // already in place, no pulses
    op(8'h70, '{0, 0, 1'h0, 1'h0, 1'h1, 4'h0});
    settle();
    // back off 5, search 5, table 12 fast
    op(8'h72, '{17, 5, 1'h1, 1'h0, 1'h1, 4'h2});
    settle();
    // pending byte abandons seek after search
    op(8'h60, '{15, 5, 1'h0, 1'h0, 1'h0, 4'h0});
    send(8'h58);
    settle();
    // rate boundary at ten, then random counts
    for (int k = 0; k < 4; k++)
    begin
      n = (k < 2) ? 10 + k : $urandom_range(30, 1);
      send(8'h80 | 8'(n));
      op(8'h58, '{n, 0, 1'(n > 10), 1'h0, 1'h0, 4'h0});
      settle();
    end
    // one-step runs: four wait in the queue, the sixth byte is dropped
    send(8'h81);
    op(8'h58, '{5, 0, 1'h0, 1'h0, 1'h0, 4'h0});
    repeat (5) send(8'h58);
    check(queue_full_o, 1'h1, "queue full");
    settle();
    check(queue_full_o, 1'h0, "queue drained");
    // blank encoder, search gives up at 200
    broken = 1'h1;
    op(8'h73, '{200, 5, 1'h0, 1'h1, 1'h0, 4'h0});
    settle();
    test_done();
  end

  // watchdog
  initial
  begin
    repeat (90000) @(posedge ref_clk_i);
    err_count++;
    test_done();
  end
endmodule

// [design/fwsc_pkg.sv]
// Purpose : shared constants and types for the filter wheel step controller
// Assumes : 100 MHz reference clock
// Notes   : position encoder is 4 bits, step counts 8 bits
package fwsc_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;  // reference clock rate
  localparam int unsigned FAST_RATE_HZ    = 60;           // fast stepping rate
  localparam int unsigned FAST_PERIOD     = CLK_HZ / FAST_RATE_HZ;  // cycles per fast step
  localparam int unsigned FAST_THRESH     = 10;           // counts above use fast rate
  localparam int unsigned BACKOFF_STEPS   = 5;            // reverse steps before search
  localparam int unsigned SEARCH_LIMIT    = 200;          // give-up count while searching
  localparam int unsigned QUEUE_DEPTH     = 4;            // request queue entries
  localparam int unsigned QPTR_W          = 2;            // queue pointer width
  localparam int unsigned POS_W           = 4;            // encoder position width
  localparam int unsigned CNT_W           = 8;            // step count width
  localparam int unsigned IVL_W           = 28;           // interval counter width
  localparam logic [7:0]  CMD_WHEEL_LO    = 8'h58;        // first wheel operation byte
  localparam logic [7:0]  CMD_WHEEL_HI    = 8'h7F;        // last wheel operation byte
  localparam logic [6:0]  DEF_STEPS_RST   = 7'h0A;        // default fixed step count
  localparam logic [POS_W-1:0] POS_INVALID = 4'hF;        // encoder code for no position
  localparam int unsigned OP_BIT          = 5;            // byte bit: 1 seek, 0 fixed
  localparam int unsigned DIR_BIT         = 4;            // byte bit: direction

  // one queued operation request
  typedef struct packed {
    logic             seek;   // seek to position, else fixed count
    logic             dir;    // commanded direction
    logic [POS_W-1:0] pos;    // target position
    logic [6:0]       steps;  // fixed step count
  } fwsc_req_t;

  // drive outputs toward the motor circuits
  typedef struct packed {
    logic step;   // one-cycle step pulse
    logic dir;    // direction level
  } fwsc_drive_t;

endpackage

// [design/fwsc_stepper.sv]
// Purpose : paces step pulses at the fast or slow interval
// Assumes : start may come during a run and reloads it
// Notes   : slow spacing stretches while yield is low
module fwsc_stepper
  import fwsc_pkg::*;
(
  input  wire logic               ref_clk_i,   // system clock
  input  wire logic               reset_n_i,   // async reset, active low
  input  wire logic               clk_en_i,    // freezes state when low
  input  wire logic               start_i,     // load a new stepping run
  input  wire logic [CNT_W-1:0]   count_i,     // pulses to issue
  input  wire logic               fast_i,      // fast rate select
  input  wire logic [IVL_W-1:0]   slow_ivl_i,  // slow interval in cycles
  input  wire logic [IVL_W-1:0]   fast_ivl_i,  // fast interval in cycles
  input  wire logic               hold_i,      // pause between pulses
  input  wire logic               yield_i,     // grants a slot, slow only
  output logic                    pulse_o,     // one step issued
  output logic                    busy_o       // run in progress
);
  import fwsc_pkg::*;

  logic [CNT_W-1:0] left, next_left;    // pulses remaining
  logic [IVL_W-1:0] tmr, next_tmr;      // interval timer
  logic             fast, next_fast;    // rate of this run
  logic             next_pulse;         // pulse next cycle

  // next values for the pacing counters
  always_comb
  begin
    next_left  = left;
    next_tmr   = tmr;
    next_fast  = fast;
    next_pulse = 1'b0;
    if (start_i)
    begin
      next_left = count_i;
      next_fast = fast_i;
      next_tmr  = fast_i ? fast_ivl_i : slow_ivl_i;
    end
    else if (left != '0 && !hold_i)
    begin
      if (tmr > IVL_W'(1))
        // slow runs wait while others have the processor
        next_tmr = (fast || yield_i) ? tmr - IVL_W'(1) : tmr;
      else
      begin
        next_pulse = 1'b1;
        next_left  = left - CNT_W'(1);
        next_tmr   = fast ? fast_ivl_i : slow_ivl_i;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      left    <= '0;
      tmr     <= '0;
      fast    <= 1'b0;
      pulse_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      left    <= next_left;
      tmr     <= next_tmr;
      fast    <= next_fast;
      pulse_o <= next_pulse;
    end
  end

  assign busy_o = (left != '0);

endmodule

// [design/fwsc_top.sv]
// Purpose : filter wheel step controller, queue to motor pulses
// Assumes : command bytes arrive as one-cycle strobes on the clock
// Notes   : encoder pins pass two flip-flops before use
module fwsc_top
  import fwsc_pkg::*;
(
  input  wire logic                   ref_clk_i,      // system clock
  input  wire logic                   reset_n_i,      // async reset, active low
  input  wire logic                   clk_en_i,       // freezes state when low
  input  wire logic                   cmd_valid_i,    // command byte strobe
  input  wire logic [7:0]             cmd_byte_i,     // command byte
  input  wire logic [IVL_W-1:0]       slow_ivl_i,     // slow interval, cycles
  input  wire logic [IVL_W-1:0]       fast_ivl_i,     // fast interval, cycles
  input  wire logic                   yield_i,        // scheduler grants a slow slot
  input  wire logic [POS_W-1:0]       encoder_i,      // wheel encoder pins
  output fwsc_pkg::fwsc_drive_t       drive_o,        // step pulse and direction
  output logic                        queue_full_o,   // request queue full
  output logic                        busy_o,         // operation active
  output logic                        hold_xfer_o,    // data transfers held off
  output logic                        thr_inhibit_o,  // threshold increment inhibit
  output logic                        seek_fail_o,    // last search found no position
  output logic [POS_W-1:0]            position_o      // believed wheel position
);
  import fwsc_pkg::*;

  typedef enum {S_IDLE, S_FIXED, S_CHECK, S_BACK, S_SEARCH, S_FOUND, S_FINAL} fwsc_state_t;

  // travel table: pulses between positions, direction-weighted
  function automatic logic [CNT_W-1:0] fwsc_travel(input logic [POS_W-1:0] from,
                                                   input logic [POS_W-1:0] to,
                                                   input logic dir);
    logic [POS_W-1:0] d;
    d = dir ? (to - from) : (from - to);
    return CNT_W'(d) * CNT_W'(6);   // six pulses per slot
  endfunction

  // true when a count calls for the fast rate
  function automatic logic fwsc_is_fast(input logic [CNT_W-1:0] n);
    return n > CNT_W'(FAST_THRESH);
  endfunction

  // encoder synchroniser
  logic [POS_W-1:0] enc_m, enc_s;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      enc_m <= POS_INVALID;
      enc_s <= POS_INVALID;
    end
    else if (clk_en_i)
    begin
      enc_m <= encoder_i;
      enc_s <= enc_m;
    end
  end

  // request queue storage
  fwsc_req_t       q_mem [QUEUE_DEPTH];          // queued requests
  logic [QPTR_W:0] q_wr, q_rd, next_q_wr, next_q_rd;  // pointers with wrap bit
  logic [6:0]      def_steps, next_def_steps;    // default fixed count
  logic            push, pop;                    // queue strobes
  fwsc_req_t       new_req;                      // decoded byte
  logic [QPTR_W:0] q_used;                       // occupancy

  assign q_used = q_wr - q_rd;

  // command decode and queue pointers
  always_comb
  begin
    next_def_steps = def_steps;
    new_req.seek   = cmd_byte_i[OP_BIT];
    new_req.dir    = cmd_byte_i[DIR_BIT];
    new_req.pos    = cmd_byte_i[POS_W-1:0];
    new_req.steps  = def_steps;
    push = 1'b0;
    if (cmd_valid_i && cmd_byte_i[7])
      next_def_steps = cmd_byte_i[6:0];
    if (cmd_valid_i && cmd_byte_i >= CMD_WHEEL_LO && cmd_byte_i <= CMD_WHEEL_HI)
      push = (q_used != (QPTR_W+1)'(QUEUE_DEPTH));
    next_q_wr = push ? q_wr + (QPTR_W+1)'(1) : q_wr;
    next_q_rd = pop ? q_rd + (QPTR_W+1)'(1) : q_rd;
  end

  // queue registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q_wr      <= '0;
      q_rd      <= '0;
      def_steps <= DEF_STEPS_RST;
    end
    else if (clk_en_i)
    begin
      q_wr      <= next_q_wr;
      q_rd      <= next_q_rd;
      def_steps <= next_def_steps;
      if (push)
        q_mem[q_wr[QPTR_W-1:0]] <= new_req;                // held in arrival order
    end
  end

  // operation state
  fwsc_state_t      st, next_st;             // sequencer state
  fwsc_req_t        cur, next_cur;           // active request
  logic [CNT_W-1:0] srch, next_srch;         // search pulses issued
  logic [POS_W-1:0] pos, next_pos;           // believed position
  logic             fail, next_fail;         // search gave up
  logic             fast_run, next_fast_run; // fast run active
  logic             dir, next_dir;           // motor direction
  logic             st_start;                // start stepper
  logic [CNT_W-1:0] st_count;                // stepper count
  logic             st_fast;                 // stepper rate
  logic             st_hold;                 // pause stepper
  logic             st_pulse, st_busy;       // stepper status

  fwsc_stepper u_stepper (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .clk_en_i   (clk_en_i),
    .start_i    (st_start),
    .count_i    (st_count),
    .fast_i     (st_fast),
    .slow_ivl_i (slow_ivl_i),
    .fast_ivl_i (fast_ivl_i),
    .hold_i     (st_hold),
    .yield_i    (yield_i),
    .pulse_o    (st_pulse),
    .busy_o     (st_busy)
  );

  // sequencer next state
  always_comb
  begin
    next_st       = st;
    next_cur      = cur;
    next_srch     = srch;
    next_pos      = pos;
    next_fail     = fail;
    next_fast_run = fast_run;
    next_dir      = dir;
    pop      = 1'b0;
    st_start = 1'b0;
    st_count = '0;
    st_fast  = 1'b0;
    st_hold  = 1'b0;
    unique case (st)
      S_IDLE:
        if (q_used != '0)
        begin
          next_cur = q_mem[q_rd[QPTR_W-1:0]];
          pop      = 1'b1;
          if (q_mem[q_rd[QPTR_W-1:0]].seek)
            next_st = S_CHECK;
          else
          begin
            st_start      = 1'b1;
            st_count      = CNT_W'(q_mem[q_rd[QPTR_W-1:0]].steps);
            st_fast       = fwsc_is_fast(st_count);
            next_fast_run = st_fast;
            next_dir      = q_mem[q_rd[QPTR_W-1:0]].dir;
            next_st       = S_FIXED;
          end
        end
      S_FIXED:
        // wait out the last pulse so busy and hold cover it
        if (!st_busy && !st_pulse)
        begin
          next_fast_run = 1'b0;
          next_st       = S_IDLE;
        end
      S_CHECK:
        if (enc_s == cur.pos)
        begin
          next_pos = enc_s;
          next_st  = S_IDLE;
        end
        else
        begin
          st_start = 1'b1;
          st_count = CNT_W'(BACKOFF_STEPS);
          next_dir = ~cur.dir;
          next_st  = S_BACK;
        end
      S_BACK:
        if (!st_busy)
        begin
          st_start  = 1'b1;
          st_count  = CNT_W'(SEARCH_LIMIT);
          next_dir  = cur.dir;
          next_srch = '0;
          next_st   = S_SEARCH;
        end
      S_SEARCH:
      begin
        st_hold = (enc_s != POS_INVALID);                    // encoder read between steps
        if (st_pulse)
          next_srch = srch + CNT_W'(1);
        if (enc_s != POS_INVALID)
        begin
          st_start  = 1'b1;                                  // reload zero stops run
          next_pos  = enc_s;
          next_fail = 1'b0;
          next_st   = S_FOUND;
        end
        else if (!st_busy && !st_pulse)
        begin
          next_fail = (srch == CNT_W'(SEARCH_LIMIT));        // limit spent
          next_st   = S_IDLE;
        end
      end
      S_FOUND:
        if (q_used != '0)                                    // checked only here
          next_st = S_IDLE;
        else
        begin
          st_start      = 1'b1;
          st_count      = fwsc_travel(pos, cur.pos, cur.dir);
          st_fast       = fwsc_is_fast(st_count);
          next_fast_run = st_fast;
          next_st       = S_FINAL;
        end
      S_FINAL:
        if (!st_busy && !st_pulse)                           // queue ignored here
        begin
          next_pos      = cur.pos;
          next_fast_run = 1'b0;
          next_st       = S_IDLE;
        end
    endcase
  end

  // sequencer registers and outputs
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st            <= S_IDLE;
      cur           <= '0;
      srch          <= '0;
      pos           <= POS_INVALID;
      fail          <= 1'b0;
      fast_run      <= 1'b0;
      dir           <= 1'b0;
      drive_o       <= '0;
      queue_full_o  <= 1'b0;
      busy_o        <= 1'b0;
      hold_xfer_o   <= 1'b0;
      thr_inhibit_o <= 1'b0;
      seek_fail_o   <= 1'b0;
      position_o    <= POS_INVALID;
    end
    else if (clk_en_i)
    begin
      st            <= next_st;
      cur           <= next_cur;
      srch          <= next_srch;
      pos           <= next_pos;
      fail          <= next_fail;
      fast_run      <= next_fast_run;
      dir           <= next_dir;
      drive_o.step  <= st_pulse;
      drive_o.dir   <= dir;
      queue_full_o  <= (next_q_wr - next_q_rd) == (QPTR_W+1)'(QUEUE_DEPTH);
      busy_o        <= (next_st != S_IDLE);
      hold_xfer_o   <= next_fast_run;
      // a pulse in flight still counts as movement
      thr_inhibit_o <= (next_st != S_IDLE) || st_busy || st_pulse;
      seek_fail_o   <= next_fail;
      position_o    <= next_pos;
    end
  end

endmodule
